// ===== rot_pkg.sv
// constants, types and register map shared by the rotate datapath
// assumes a 32-bit classic wishbone slave and a 12-bit file address
package rot_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00; // extended set enable
  localparam logic [7:0] OFF_INSN = 8'h04; // write executes
  localparam logic [7:0] OFF_WREG = 8'h08; // working register
  localparam logic [7:0] OFF_STATUS = 8'h0c; // flags
  localparam logic [7:0] OFF_FDATA = 8'h10; // addressed file byte
  localparam logic [7:0] OFF_BANK = 8'h14; // bank pointer register
  localparam logic [7:0] OFF_INDEX = 8'h18; // index base for offsets
  localparam logic [7:0] OFF_EADDR = 8'h1c; // resolved address, ro

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EXT_BIT = 0;
  localparam int STAT_C_BIT = 0;
  localparam int STAT_Z_BIT = 1;
  localparam int STAT_N_BIT = 2;
  localparam int STAT_BAD_BIT = 3; // sticky: unsupported opcode
  localparam int EA_IDX_BIT = 16; // last operand was indexed
  localparam int EA_DST_BIT = 17; // last result went to file

  // ----------------------------------------------------------------
  // widths, opcodes, address map
  // ----------------------------------------------------------------
  localparam int BANK_W = 4;
  localparam int ADDR_W = 12;
  localparam logic [5:0] OPC_RLNC = 6'h11; // 0100 01
  localparam logic [5:0] OPC_RRC = 6'h0c; // 0011 00
  localparam logic [7:0] EXT_LAST = 8'h5f; // highest indexed offset
  localparam logic [7:0] ACC_SPLIT = 8'h60; // access bank low/high
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [7:0] FDATA_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [11:0] INDEX_RST = 12'h000;
  localparam logic [15:0] INSN_RST = 16'h0000;
  localparam logic [11:0] EADDR_RST = 12'h000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] opc; // operation prefix
    logic d; // destination select
    logic a; // bank access select
    logic [7:0] f; // operand address
  } insn_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
  } flags_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b001,
    OP_RLNC = 3'b010,
    OP_RRC = 3'b100
  } op_t;

endpackage

// ===== byte_rotate_unit.sv
// combinational rotate and flag logic for one byte
// assumes the caller latches result and flags on its own clock
`timescale 1ns/10ps
module byte_rotate_unit (
  input wire rot_pkg::op_t op,
  input wire logic [7:0] operand,
  input wire logic carry_in,
  output logic [7:0] result,
  output rot_pkg::flags_t flags
);

  // ----------------------------------------------------------------
  // rotate paths
  // ----------------------------------------------------------------
  wire logic [7:0] rot_left; // bit 7 wraps into bit 0
  wire logic [7:0] rot_right; // old carry enters bit 7
  wire logic is_rrc;
  wire logic is_rlnc;
  wire logic c_w;

  assign rot_left = {operand[6:0], operand[7]};
  assign rot_right = {carry_in, operand[7:1]};
  assign is_rrc = (op == rot_pkg::OP_RRC);
  assign is_rlnc = (op == rot_pkg::OP_RLNC);

  // unknown op passes the operand through untouched
  assign result = is_rrc ? rot_right : (is_rlnc ? rot_left : operand);
  // carry only moves on the right rotate
  assign c_w = is_rrc ? operand[0] : carry_in;
  // flags follow the byte that gets written
  assign flags = {result[7], (result == 8'h00), c_w};

endmodule

// ===== operand_addr_resolve.sv
// resolves the 8-bit operand address into the 12-bit file space
// assumes bank pointer and index base are stable registers
`timescale 1ns/10ps
module operand_addr_resolve (
  input wire logic [7:0] f,
  input wire logic bank_sel,
  input wire logic ext_en,
  input wire logic [rot_pkg::BANK_W-1:0] bank,
  input wire logic [rot_pkg::ADDR_W-1:0] index_base,
  output logic [rot_pkg::ADDR_W-1:0] eaddr,
  output logic indexed
);

  // ----------------------------------------------------------------
  // candidate addresses
  // ----------------------------------------------------------------
  wire logic [rot_pkg::ADDR_W-1:0] access_addr;
  wire logic [rot_pkg::ADDR_W-1:0] banked_addr;
  wire logic [rot_pkg::ADDR_W-1:0] index_addr;

  // low offsets hit bank 0, the rest the special-function top bank
  assign access_addr = (f < rot_pkg::ACC_SPLIT) ?
    {rot_pkg::ACC_LO_BANK, f} : {rot_pkg::ACC_HI_BANK, f};
  assign banked_addr = {bank, f};
  // wraps at the top of the space, as the index base itself does
  assign index_addr = index_base + {4'h0, f};

  // indexed mode only overrides the access bank, never the banked path
  assign indexed = ext_en & ~bank_sel & (f <= rot_pkg::EXT_LAST);
  assign eaddr = indexed ? index_addr :
    (bank_sel ? banked_addr : access_addr);

endmodule

// ===== byte_rotate_datapath.sv
// top of the byte rotate datapath with its wishbone register slave
// assumes a classic wishbone master on sys_clk, one request at a time
`timescale 1ns/10ps
module byte_rotate_datapath (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  output logic exec_done
);

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  logic ack_r; // bus acknowledge
  logic [31:0] dat_r; // bus read data
  logic done_r; // one-cycle pulse after a supported execute
  logic ext_r; // extended set enable
  rot_pkg::insn_t insn_r; // last instruction word taken
  logic [7:0] wreg_r; // working register
  logic [7:0] fdata_r; // addressed file byte
  rot_pkg::flags_t flags_r; // C, Z, N
  logic bad_r; // sticky unsupported opcode
  logic [rot_pkg::BANK_W-1:0] bank_r; // bank pointer register
  logic [rot_pkg::ADDR_W-1:0] index_r; // index base
  logic [rot_pkg::ADDR_W-1:0] eaddr_r; // last resolved address
  logic idx_r; // last operand was indexed
  logic dst_r; // last result went to file

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic req; // a request is on the bus
  wire logic ack_nxt;
  wire logic wr_go; // write commits at the edge ack is seen
  wire logic hit_ctrl;
  wire logic hit_insn;
  wire logic hit_wreg;
  wire logic hit_status;
  wire logic hit_fdata;
  wire logic hit_bank;
  wire logic hit_index;
  wire logic hit_eaddr;
  wire logic [31:0] bmask; // byte lanes from sel
  wire logic [31:0] rd_word; // readback of the addressed register
  wire logic [31:0] wr_val; // readback merged with written lanes
  wire logic [31:0] dat_nxt;

  assign req = wb_cyc & wb_stb;
  // one wait state: ack rises the cycle after the request, then drops
  assign ack_nxt = req & ~ack_r;
  assign wr_go = req & wb_we & ack_r;

  assign hit_ctrl = (wb_adr == rot_pkg::OFF_CTRL);
  assign hit_insn = (wb_adr == rot_pkg::OFF_INSN);
  assign hit_wreg = (wb_adr == rot_pkg::OFF_WREG);
  assign hit_status = (wb_adr == rot_pkg::OFF_STATUS);
  assign hit_fdata = (wb_adr == rot_pkg::OFF_FDATA);
  assign hit_bank = (wb_adr == rot_pkg::OFF_BANK);
  assign hit_index = (wb_adr == rot_pkg::OFF_INDEX);
  assign hit_eaddr = (wb_adr == rot_pkg::OFF_EADDR);

  assign bmask = {{8{wb_sel[3]}}, {8{wb_sel[2]}},
    {8{wb_sel[1]}}, {8{wb_sel[0]}}};

  // ----------------------------------------------------------------
  // readback words, unused bits read as zero
  // ----------------------------------------------------------------
  wire logic [31:0] ctrl_word;
  wire logic [31:0] status_word;
  wire logic [31:0] eaddr_word;

  assign ctrl_word = {31'h0, ext_r};
  assign status_word = {28'h0, bad_r, flags_r};
  assign eaddr_word = {14'h0, dst_r, idx_r, 4'h0, eaddr_r};

  // unmapped offsets read as zero and ignore writes
  assign rd_word = hit_ctrl ? ctrl_word :
    hit_insn ? {16'h0, insn_r} :
    hit_wreg ? {24'h0, wreg_r} :
    hit_status ? status_word :
    hit_fdata ? {24'h0, fdata_r} :
    hit_bank ? {28'h0, bank_r} :
    hit_index ? {20'h0, index_r} :
    hit_eaddr ? eaddr_word : 32'h0;

  // lanes not enabled keep their current value
  assign wr_val = (rd_word & ~bmask) | (wb_dat_w & bmask);
  assign dat_nxt = (ack_nxt & ~wb_we) ? rd_word : 32'h0;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  wire rot_pkg::insn_t insn_w; // instruction being written
  wire rot_pkg::op_t op; // decoded operation
  wire logic exec; // instruction word committed
  wire logic exec_ok; // committed and supported
  wire logic exec_bad; // committed but unsupported
  wire logic d_now;
  wire logic a_now;
  wire logic [7:0] f_now;
  wire logic carry_now;

  assign insn_w = wr_val[15:0];
  assign d_now = insn_w.d;
  assign a_now = insn_w.a;
  assign f_now = insn_w.f;
  assign carry_now = flags_r.c;

  assign op = (insn_w.opc == rot_pkg::OPC_RLNC) ? rot_pkg::OP_RLNC :
    (insn_w.opc == rot_pkg::OPC_RRC) ? rot_pkg::OP_RRC :
    rot_pkg::OP_NONE;

  assign exec = wr_go & hit_insn;
  assign exec_ok = exec & (op != rot_pkg::OP_NONE);
  assign exec_bad = exec & (op == rot_pkg::OP_NONE);

  // ----------------------------------------------------------------
  // datapath units
  // ----------------------------------------------------------------
  wire logic [7:0] unit_res;
  wire rot_pkg::flags_t unit_flags;
  wire logic [rot_pkg::ADDR_W-1:0] unit_addr;
  wire logic unit_idx;

  // the file byte register stands in for the addressed file location
  byte_rotate_unit u_rot (
    .op(op),
    .operand(fdata_r),
    .carry_in(carry_now),
    .result(unit_res),
    .flags(unit_flags)
  );

  operand_addr_resolve u_addr (
    .f(f_now),
    .bank_sel(a_now),
    .ext_en(ext_r),
    .bank(bank_r),
    .index_base(index_r),
    .eaddr(unit_addr),
    .indexed(unit_idx)
  );

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  wire logic to_file; // execute writes the file byte
  wire logic to_wreg; // execute writes the working register
  wire logic ext_nxt;
  wire rot_pkg::insn_t insn_nxt;
  wire logic [7:0] wreg_nxt;
  wire logic [7:0] fdata_nxt;
  wire rot_pkg::flags_t flags_nxt;
  wire logic bad_nxt;
  wire logic [rot_pkg::BANK_W-1:0] bank_nxt;
  wire logic [rot_pkg::ADDR_W-1:0] index_nxt;

  assign to_file = exec_ok & d_now;
  assign to_wreg = exec_ok & ~d_now;

  assign ext_nxt = (wr_go & hit_ctrl) ? wr_val[rot_pkg::CTRL_EXT_BIT] : ext_r;
  assign insn_nxt = exec ? insn_w : insn_r;
  // whole result lands in one cycle, no multi-step sequencing
  assign wreg_nxt = to_wreg ? unit_res :
    (wr_go & hit_wreg) ? wr_val[7:0] : wreg_r;
  assign fdata_nxt = to_file ? unit_res :
    (wr_go & hit_fdata) ? wr_val[7:0] : fdata_r;
  // left rotate hands carry through unchanged inside the unit
  assign flags_nxt = exec_ok ? unit_flags :
    (wr_go & hit_status) ? wr_val[2:0] : flags_r;
  // hardware set wins over a software write in the same cycle
  assign bad_nxt = exec_bad |
    ((wr_go & hit_status) ? wr_val[rot_pkg::STAT_BAD_BIT] : bad_r);
  assign bank_nxt = (wr_go & hit_bank) ? wr_val[3:0] : bank_r;
  assign index_nxt = (wr_go & hit_index) ? wr_val[11:0] : index_r;

  // ----------------------------------------------------------------
  // bus handshake registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      done_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      done_r <= exec_ok;
    end
  end

  // ----------------------------------------------------------------
  // software-visible registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ext_r <= 1'b0;
      insn_r <= rot_pkg::INSN_RST;
      wreg_r <= rot_pkg::WREG_RST;
      fdata_r <= rot_pkg::FDATA_RST;
      flags_r <= 3'h0;
      bad_r <= 1'b0;
      bank_r <= rot_pkg::BANK_RST;
      index_r <= rot_pkg::INDEX_RST;
    end else begin
      ext_r <= ext_nxt;
      insn_r <= insn_nxt;
      wreg_r <= wreg_nxt;
      fdata_r <= fdata_nxt;
      flags_r <= flags_nxt;
      bad_r <= bad_nxt;
      bank_r <= bank_nxt;
      index_r <= index_nxt;
    end
  end

  // ----------------------------------------------------------------
  // last operand address, kept for software to inspect
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      eaddr_r <= rot_pkg::EADDR_RST;
      idx_r <= 1'b0;
      dst_r <= 1'b0;
    end else if (exec_ok) begin
      eaddr_r <= unit_addr;
      idx_r <= unit_idx;
      dst_r <= d_now;
    end
  end

  assign wb_ack = ack_r;
  assign wb_dat_r = dat_r;
  assign exec_done = done_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // expected rotations built apart from the unit
  wire logic [7:0] exp_rl;
  wire logic [7:0] exp_rr;
  wire logic fbit0;
  wire logic [3:0] exp_acc_bank;

  assign exp_rl = {fdata_r[6:0], fdata_r[7]};
  assign exp_rr = {carry_now, fdata_r[7:1]};
  assign fbit0 = fdata_r[0];
  assign exp_acc_bank = (f_now < rot_pkg::ACC_SPLIT) ?
    rot_pkg::ACC_LO_BANK : rot_pkg::ACC_HI_BANK;

  sequence s_rlnc;
    exec_ok && (op == rot_pkg::OP_RLNC);
  endsequence

  sequence s_rrc;
    exec_ok && (op == rot_pkg::OP_RRC);
  endsequence

  sequence s_direct;
    exec_ok && !a_now && !(ext_r && (f_now <= rot_pkg::EXT_LAST));
  endsequence

  // bus: ack one cycle after request, then low again
  bus_ack_pulse_a: assert property (req && !ack_r |=> ack_r ##1 !ack_r)
    else $error("wishbone ack not a single wait-state pulse");

  rlnc_file_a: assert property (s_rlnc ##0 d_now |=>
    (fdata_r == $past(exp_rl)) && (flags_r.c == $past(carry_now)))
    else $error("left rotate to file wrong or carry touched");

  rlnc_to_w_a: assert property (s_rlnc ##0 !d_now |=>
    (wreg_r == $past(exp_rl)) && $stable(fdata_r))
    else $error("left rotate with d=0 did not go to W only");

  bank_select_a: assert property (exec_ok && a_now |=>
    (eaddr_r == {$past(bank_r), $past(f_now)}) && !idx_r)
    else $error("banked operand address wrong");

  access_map_a: assert property (s_direct |=>
    (eaddr_r == {$past(exp_acc_bank), $past(f_now)}) && !idx_r)
    else $error("access bank operand address wrong");

  indexed_addr_a: assert property (exec_ok && !a_now && ext_r &&
    (f_now <= rot_pkg::EXT_LAST) |=>
    idx_r && (eaddr_r == $past(index_r) + {4'h0, $past(f_now)}))
    else $error("indexed offset address wrong");

  rrc_carry_a: assert property (s_rrc |=>
    (flags_r.c == $past(fbit0)) &&
    ($past(d_now) ? (fdata_r == $past(exp_rr)) : (wreg_r == $past(exp_rr))))
    else $error("right rotate through carry wrong");

  flag_update_a: assert property (exec_ok |=> exec_done &&
    (flags_r.z == (($past(d_now) ? fdata_r : wreg_r) == 8'h00)) &&
    (flags_r.n == ($past(d_now) ? fdata_r[7] : wreg_r[7])))
    else $error("N or Z flag does not match result");

  bad_op_a: assert property (exec_bad |=> bad_r && !exec_done &&
    $stable(wreg_r) && $stable(fdata_r) && $stable(flags_r))
    else $error("unsupported opcode changed data or not flagged");

endmodule

// ===== tb_top.sv
// self-checking bench for the byte rotate datapath, reached over classic wishbone
// assumes the block's register map: one cycle ack latency, exec_done the cycle after the ack
`timescale 1ns/10ps
module tb_top;

  // ----------------------------------------------------------------
  // stimulus signals and bookkeeping
  // ----------------------------------------------------------------
  logic sys_clk = 1'h0; // 250 mhz core clock
  logic srst = 1'h1; // synchronous reset, held at start
  logic wb_cyc = 1'h0;
  logic wb_stb = 1'h0;
  logic wb_we = 1'h0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic exec_done;
  int err_total = 0; // mismatches seen
  int cmp_count = 0; // comparisons made
  logic [31:0] rd; // read data taken at the ack edge
  logic done_now; // exec_done just after the ack edge
  logic done_next; // exec_done one cycle later
  // reference state of the block, kept by the bench
  logic m_ext, m_c, m_n, m_z, m_bad, m_done;
  logic [7:0] m_w, m_f;
  logic [3:0] m_bank;
  logic [11:0] m_index;
  logic [15:0] m_insn;
  logic [31:0] m_ea;

  byte_rotate_datapath i_byte_rotate_datapath (
    .sys_clk(sys_clk), .srst(srst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .exec_done(exec_done)
  );

  // clock: invert every half period
  always #2 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  // single exit point for the run, also used by the watchdog
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // wishbone master: one classic cycle, held until ack is sampled high
  // ----------------------------------------------------------------
  task wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_dat_w <= dat;
    // the slave answers one cycle after taking the request; wait bounded anyway
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'h1 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("ERROR at %0t: no ack", $time);
    end
    rd = wb_dat_r;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    wb_we <= 1'h0;
    #1 done_now = exec_done;
    @(posedge sys_clk);
    #1 done_next = exec_done;
  endtask

  task wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_cycle(1'h1, adr, 4'hf, dat);
  endtask

  task rdc(input logic [7:0] adr, input logic [31:0] exp, input string what);
    wb_cycle(1'h0, adr, 4'hf, 32'h0);
    chk(rd, exp, what);
  endtask

  // ----------------------------------------------------------------
  // reference functions
  // ----------------------------------------------------------------
  // returns {indexed, 12-bit address}
  function automatic logic [12:0] res_addr(input logic ext, input logic a,
      input logic [7:0] f, input logic [3:0] bank, input logic [11:0] index);
    if (ext && !a && f <= 8'h5f) return {1'h1, index + {4'h0, f}};
    if (a) return {1'h0, bank, f};
    if (f < 8'h60) return {1'h0, 4'h0, f};
    return {1'h0, 4'hf, f};
  endfunction

  // returns {carry out, result}; left rotate leaves carry as it was
  function automatic logic [8:0] rot(input logic left, input logic c, input logic [7:0] f);
    if (left) return {c, f[6:0], f[7]};
    return {f[0], c, f[7:1]};
  endfunction

  // applies one instruction to the reference state
  task model_exec(input logic [15:0] insn);
    logic [12:0] ra;
    logic [8:0] rr;
    m_insn = insn;
    m_done = 1'h0;
    if (insn[15:10] !== rot_pkg::OPC_RLNC && insn[15:10] !== rot_pkg::OPC_RRC) begin
      m_bad = 1'h1; // unsupported: only the sticky flag and the instruction word move
    end else begin
      ra = res_addr(m_ext, insn[8], insn[7:0], m_bank, m_index);
      rr = rot(insn[15:10] == rot_pkg::OPC_RLNC, m_c, m_f);
      m_c = rr[8];
      m_n = rr[7];
      m_z = (rr[7:0] == 8'h00);
      if (insn[9]) m_f = rr[7:0];
      else m_w = rr[7:0];
      m_ea = {14'h0, insn[9], ra[12], 4'h0, ra[11:0]};
      m_done = 1'h1;
    end
  endtask

  // writes an instruction with the given lanes, then compares everything an execute can change (not ctrl, bank or index)
  task run_insn(input logic [3:0] sel, input logic [15:0] dat, input logic [15:0] merged);
    wb_cycle(1'h1, rot_pkg::OFF_INSN, sel, {16'h0, dat});
    model_exec(merged);
    chk({31'h0, done_now}, {31'h0, m_done}, "exec_done pulse");
    chk({31'h0, done_next}, 32'h0, "exec_done width");
    rdc(rot_pkg::OFF_WREG, {24'h0, m_w}, "wreg");
    rdc(rot_pkg::OFF_FDATA, {24'h0, m_f}, "file byte");
    rdc(rot_pkg::OFF_STATUS, {28'h0, m_bad, m_n, m_z, m_c}, "status");
    rdc(rot_pkg::OFF_EADDR, m_ea, "resolved address");
    rdc(rot_pkg::OFF_INSN, {16'h0, m_insn}, "insn readback");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v [0:5];
    logic [5:0] opc;
    logic d, a;
    logic [7:0] fa;
    logic [15:0] iw;
    void'($urandom(64));
    repeat (20) @(posedge sys_clk);
    srst <= 1'h0;
    // every register, and one unmapped place, reads zero after reset
    for (int k = 0; k <= 8; k++) rdc(8'(k * 4), 32'h0, "reset value");
    {m_ea, m_insn, m_bad} = '0;
    for (int i = 0; i < 48; i++) begin
      for (int k = 0; k < 6; k++) v[k] = $urandom;
      opc = v[5][0] ? rot_pkg::OPC_RLNC : rot_pkg::OPC_RRC;
      {d, a, fa} = v[5][10:1];
      v[5][3] = 1'h0; // keep the sticky flag clear during the sweep
      // corners: indexed boundary, access split, zero results, offset wrap
      case (i)
        0: begin v[0][0] = 1'h1; a = 1'h0; fa = 8'h5f; end
        1: begin v[0][0] = 1'h1; a = 1'h0; fa = 8'h60; end
        2: begin v[4] = 32'h0; end
        3: begin opc = rot_pkg::OPC_RRC; v[4] = 32'h1; v[5][0] = 1'h0; end
        4: begin v[0][0] = 1'h1; a = 1'h0; fa = 8'h01; v[2] = 32'hfff; end
        5: begin opc = rot_pkg::OPC_RLNC; v[4] = 32'h80; d = 1'h0; end
        default: ;
      endcase
      wr(rot_pkg::OFF_CTRL, v[0]);
      wr(rot_pkg::OFF_BANK, v[1]);
      wr(rot_pkg::OFF_INDEX, v[2]);
      wr(rot_pkg::OFF_WREG, v[3]);
      wr(rot_pkg::OFF_FDATA, v[4]);
      wr(rot_pkg::OFF_STATUS, v[5]);
      m_ext = v[0][0];
      m_bank = v[1][3:0];
      m_index = v[2][11:0];
      m_w = v[3][7:0];
      m_f = v[4][7:0];
      {m_bad, m_n, m_z, m_c} = v[5][3:0];
      iw = {opc, d, a, fa};
      run_insn(4'hf, iw, iw);
    end
    // unsupported prefix: nothing but the sticky flag and the instruction word change
    iw = {6'h3f, 1'h1, 1'h1, 8'h5a};
    run_insn(4'hf, iw, iw);
    // upper lane alone turns it into a left rotate of the kept operand address
    run_insn(4'h2, {rot_pkg::OPC_RLNC, 2'h3, 8'h00}, {rot_pkg::OPC_RLNC, 2'h3, 8'h5a});
    // read-only and unmapped places ignore writes
    wr(rot_pkg::OFF_EADDR, 32'hffffffff);
    rdc(rot_pkg::OFF_EADDR, m_ea, "eaddr write ignored");
    wr(8'h40, 32'hffffffff);
    rdc(8'h40, 32'h0, "unmapped read");
    test_done;
  end

  // watchdog: the sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    $display("ERROR at %0t: watchdog expired", $time);
    test_done;
  end

endmodule
